// File: logic/countdown_regs.vh
// How it works
// - auto-restart set: reload preset on expiry
// - auto-restart clear: stop at zero, set flag
// - tick rate is clock over two-power exponent
// - receive-finish halt when bit 3 set
// - first-received-bit halt when bit 2 set
// - transmit-finish launch when bit 1 set
// - first-sent-bit launch when bit 0 set
// - launch while running reloads the counter
// - every launch loads the eight-bit preset
// - preset writes take effect at the next launch or auto-restart reload
// - zero preset never launches the timer
// - invert bit flips irq pin level
// - active-drive bit selects push-pull or open drain
`ifndef COUNTDOWN_REGS_VH
`define COUNTDOWN_REGS_VH
// register addresses
`define TICK_CONFIG_ADDR 8'h2a
`define TRIGGER_CONTROL_ADDR 8'h2b
`define PRESET_ADDR 8'h2c
`define IRQ_STAGE_ADDR 8'h2d
`define FIXED_A_ADDR 8'h2e
`define FIXED_B_ADDR 8'h2f
// reset values
`define TICK_CONFIG_RST 8'h0b
`define TRIGGER_CONTROL_RST 8'h02
`define PRESET_RST 8'h00
`define IRQ_STAGE_RST 8'h02
`define FIXED_RST 8'h00
// field positions
`define RELOAD_ON_EXPIRY_BIT 5
`define EXPONENT_MSB 4
`define HALT_RX_FINISH_BIT 3
`define HALT_RX_FIRST_BIT 2
`define LAUNCH_TX_FINISH_BIT 1
`define LAUNCH_TX_FIRST_BIT 0
`define IRQ_INVERT_BIT 1
`define IRQ_ACTIVE_DRIVE_BIT 0
// largest usable exponent
`define EXPONENT_MAX 5'h0f
`endif

// File: logic/tick_divider.v
`timescale 1ns/1ps
`default_nettype none
`include "countdown_regs.vh"
module tick_divider
#(
  parameter WIDTH = 16
)
(
  // clock and reset
  input wire ref_clk_in,
  input wire nrst_in,
  // control
  input wire run_in,
  input wire [4:0] exponent_in,
  // tick out
  output reg tick_out
);
  // free counter, cleared while idle so each launch starts a full period
  reg [WIDTH-1:0] count_reg;
  // exponent limited to the usable range
  wire [4:0] exp_lim = (exponent_in > `EXPONENT_MAX) ? `EXPONENT_MAX : exponent_in;
  // terminal count mask: low exp bits all ones
  wire [WIDTH-1:0] mask = ({{(WIDTH-1){1'b0}}, 1'b1} << exp_lim) - {{(WIDTH-1){1'b0}}, 1'b1};

  // divider: one pulse every 2^exp clocks
  always @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      count_reg <= {WIDTH{1'b0}};
      tick_out <= 1'b0;
    end
    else if (!run_in)
    begin
      count_reg <= {WIDTH{1'b0}};
      tick_out <= 1'b0;
    end
    else
    begin
      // pulse when the masked bits are full
      tick_out <= ((count_reg & mask) == mask);
      count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// File: logic/countdown_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "countdown_regs.vh"
module countdown_timer
(
  // clock and reset
  input wire ref_clk_in,
  input wire nrst_in,
  // register port
  input wire [7:0] addr_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] wdata_in,
  output reg [7:0] rdata_out,
  // link events, one-cycle pulses
  input wire tx_first_bit_in,
  input wire tx_finish_in,
  input wire rx_first_bit_in,
  input wire rx_finish_in,
  // interrupt request bit and its clear
  input wire irq_bit_in,
  input wire flag_clear_in,
  output reg countdown_expired_flag_out,
  // status
  output reg running_out,
  output reg [7:0] count_out,
  // irq pin
  output reg irq_pin_out,
  output reg irq_pin_oe_out
);
  // one-hot states
  localparam IDLE = 2'b01;
  localparam RUN = 2'b10;

  // registers
  reg [7:0] tick_config_reg;
  reg [7:0] trigger_control_reg;
  reg [7:0] preset_reg;
  reg [7:0] irq_stage_reg;
  reg [7:0] fixed_a_reg;
  reg [7:0] fixed_b_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] count_next;
  reg flag_next;
  wire tick;

  // control fields
  wire reload_on_expiry = tick_config_reg[`RELOAD_ON_EXPIRY_BIT];
  wire [4:0] tick_divider_exponent = tick_config_reg[`EXPONENT_MSB:0];
  // launch and halt conditions
  wire launch = (trigger_control_reg[`LAUNCH_TX_FIRST_BIT] & tx_first_bit_in)
              | (trigger_control_reg[`LAUNCH_TX_FINISH_BIT] & tx_finish_in);
  wire halt = (trigger_control_reg[`HALT_RX_FIRST_BIT] & rx_first_bit_in)
            | (trigger_control_reg[`HALT_RX_FINISH_BIT] & rx_finish_in);
  // irq level before the output stage
  wire irq_level = irq_bit_in ^ irq_stage_reg[`IRQ_INVERT_BIT];

  // prescaler
  tick_divider #(.WIDTH(16)) u_div
  (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .run_in(state_reg == RUN && !launch),
    .exponent_in(tick_divider_exponent),
    .tick_out(tick)
  );

  // register writes; host keeps reserved bits as they are
  always @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      tick_config_reg <= `TICK_CONFIG_RST;
      trigger_control_reg <= `TRIGGER_CONTROL_RST;
      preset_reg <= `PRESET_RST;
      irq_stage_reg <= `IRQ_STAGE_RST;
      fixed_a_reg <= `FIXED_RST;
      fixed_b_reg <= `FIXED_RST;
    end
    else if (wr_in)
    begin
      // address decode
      if (addr_in == `TICK_CONFIG_ADDR)
        tick_config_reg <= wdata_in;
      else if (addr_in == `TRIGGER_CONTROL_ADDR)
        trigger_control_reg <= wdata_in;
      else if (addr_in == `PRESET_ADDR)
        preset_reg <= wdata_in;
      else if (addr_in == `IRQ_STAGE_ADDR)
        irq_stage_reg <= wdata_in;
      else if (addr_in == `FIXED_A_ADDR)
        fixed_a_reg <= wdata_in;
      else if (addr_in == `FIXED_B_ADDR)
        fixed_b_reg <= wdata_in;
    end
  end

  // read data, registered; unmapped reads zero
  always @(posedge ref_clk_in)
  begin
    if (!nrst_in)
      rdata_out <= 8'h00;
    else if (rd_in)
    begin
      if (addr_in == `TICK_CONFIG_ADDR)
        rdata_out <= tick_config_reg;
      else if (addr_in == `TRIGGER_CONTROL_ADDR)
        rdata_out <= trigger_control_reg;
      else if (addr_in == `PRESET_ADDR)
        rdata_out <= preset_reg;
      else if (addr_in == `IRQ_STAGE_ADDR)
        rdata_out <= irq_stage_reg;
      else if (addr_in == `FIXED_A_ADDR)
        rdata_out <= fixed_a_reg;
      else if (addr_in == `FIXED_B_ADDR)
        rdata_out <= fixed_b_reg;
      else
        rdata_out <= 8'h00;
    end
  end

  // countdown state machine
  always @*
  begin
    state_next = state_reg;
    count_next = count_out;
    flag_next = countdown_expired_flag_out & ~flag_clear_in;
    case (state_reg)
      IDLE:
      begin
        // zero preset blocks the launch
        if (launch && preset_reg != 8'h00)
        begin
          state_next = RUN;
          count_next = preset_reg;
        end
      end
      RUN:
      begin
        if (launch && preset_reg != 8'h00)
          count_next = preset_reg;
        else if (halt)
          state_next = IDLE;
        else if (tick)
        begin
          if (count_out == 8'h01 || count_out == 8'h00)
          begin
            if (reload_on_expiry)
              count_next = preset_reg;
            else
            begin
              // stop at zero and raise the flag; set beats clear
              count_next = 8'h00;
              flag_next = 1'b1;
              state_next = IDLE;
            end
          end
          else
            count_next = count_out - 8'h01;
        end
      end
      default:
        state_next = IDLE;
    endcase
  end

  // state and output flops
  always @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      state_reg <= IDLE;
      count_out <= 8'h00;
      countdown_expired_flag_out <= 1'b0;
      running_out <= 1'b0;
      irq_pin_out <= 1'b0;
      irq_pin_oe_out <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      count_out <= count_next;
      countdown_expired_flag_out <= flag_next;
      running_out <= (state_next == RUN);
      // push-pull drives both levels, open drain only low
      irq_pin_out <= irq_level;
      irq_pin_oe_out <= irq_stage_reg[`IRQ_ACTIVE_DRIVE_BIT] | ~irq_level;
    end
  end
endmodule
`default_nettype wire

// File: tb/countdown_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "countdown_regs.vh"
module countdown_timer_monitor (
  // clock, reset and register port
  input wire logic ref_clk_in, nrst_in, wr_in, rd_in,
  input wire logic [7:0] addr_in, wdata_in, rdata_out, count_out,
  // events, irq and status
  input wire logic tx_first_bit_in, tx_finish_in, rx_first_bit_in, rx_finish_in, irq_bit_in, flag_clear_in,
  input wire logic countdown_expired_flag_out, running_out, irq_pin_out, irq_pin_oe_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  // shadow copies of control, preset and pin stage
  logic [7:0] ctl_reg, pre_reg, stg_reg;
  wire logic go = (tx_first_bit_in & ctl_reg[0]) | (tx_finish_in & ctl_reg[1]);
  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      ctl_reg <= `TRIGGER_CONTROL_RST;
      pre_reg <= `PRESET_RST;
      stg_reg <= `IRQ_STAGE_RST;
    end
    else if (wr_in)
    begin
      if (addr_in == `TRIGGER_CONTROL_ADDR)
        ctl_reg <= wdata_in;
      if (addr_in == `PRESET_ADDR)
        pre_reg <= wdata_in;
      if (addr_in == `IRQ_STAGE_ADDR)
        stg_reg <= wdata_in;
    end
  end
  // three cycles without writes, so the pin stage has settled
  sequence s_quiet; !wr_in [*3]; endsequence
  property p_launch; go && pre_reg != 8'h00 |=> running_out && count_out == $past(pre_reg); endproperty
  a_launch: assert property (p_launch) else $error("launch lost");
  property p_zero; go && pre_reg == 8'h00 && !running_out |=> !running_out; endproperty
  a_zero: assert property (p_zero) else $error("zero preset ran");
  property p_halt_end; rx_finish_in && ctl_reg[3] && !go |=> !running_out; endproperty
  a_halt_end: assert property (p_halt_end) else $error("no halt at end");
  property p_halt_first; rx_first_bit_in && ctl_reg[2] && !go |=> !running_out; endproperty
  a_halt_first: assert property (p_halt_first) else $error("no halt at first");
  property p_no_halt;
    (rx_first_bit_in || rx_finish_in) && ctl_reg[3:2] == 2'b00 && running_out && count_out > 8'h01 |=> running_out;
  endproperty
  a_no_halt: assert property (p_no_halt) else $error("halted");
  property p_flag; $rose(countdown_expired_flag_out) |-> $past(count_out) == 8'h01; endproperty
  a_flag: assert property (p_flag) else $error("early flag");
  property p_run_nz; running_out |-> count_out != 8'h00; endproperty
  a_run_nz: assert property (p_run_nz) else $error("ran at zero");
  property p_pin; s_quiet |-> irq_pin_out == ($past(irq_bit_in) ^ stg_reg[1]); endproperty
  a_pin: assert property (p_pin) else $error("pin level");
  property p_oe; s_quiet |-> irq_pin_oe_out == (stg_reg[0] | !irq_pin_out); endproperty
  a_oe: assert property (p_oe) else $error("pin drive");
endmodule
`default_nettype wire

// File: tb/irq_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module irq_host_model (
  // pin and enable from the device
  input wire logic pin_in,
  input wire logic oe_in,
  // level the host sees
  output logic level_out
);
  // a released line floats up through the pull-up
  assign level_out = oe_in ? pin_in : 1'b1;
endmodule
`default_nettype wire

// File: tb/countdown_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module countdown_timer_tb_top;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, irqb = 0, fclr = 0;
  logic [7:0] addr = 0, wdata = 0;
  logic [3:0] ev = 0; // tx first, tx end, rx first, rx end
  wire logic [7:0] rdata, count;
  wire logic flag, run, pin, oe, seen;
  int err_total = 0, tests_run = 0, cyc = 0;
  always #5 clk = ~clk;
  countdown_timer countdown_timer_inst (.ref_clk_in(clk), .nrst_in(nrst), .addr_in(addr), .wr_in(wr), .rd_in(rd),
    .wdata_in(wdata), .rdata_out(rdata), .tx_first_bit_in(ev[0]), .tx_finish_in(ev[1]), .rx_first_bit_in(ev[2]),
    .rx_finish_in(ev[3]), .irq_bit_in(irqb), .flag_clear_in(fclr), .countdown_expired_flag_out(flag),
    .running_out(run), .count_out(count), .irq_pin_out(pin), .irq_pin_oe_out(oe));
  irq_host_model irq_host_model_inst (.pin_in(pin), .oe_in(oe), .level_out(seen));
  task automatic complete_run;
    $display("compares %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %0t %h %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // register write, reserved bits always zero
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    tick(1);
    rd <= 0;
    chk(rdata, e);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1;
    tick(1);
    ev <= 0;
  endtask
  task automatic t_oneshot;
    wr8(8'h2a, 8'h00);
    wr8(8'h2c, 8'h02);
    wr8(8'h2b, 8'h01);
    pulse(0);
    chk(count, 8'h02);
    tick(3);
    chk({flag, run, count}, 10'h200);
  endtask
  task automatic t_prescale;
    fclr <= 1;
    tick(1);
    fclr <= 0;
    chk(flag, 8'h00);
    wr8(8'h2a, 8'h03);
    wr8(8'h2b, 8'h02);
    pulse(1);
    pulse(2);
    pulse(3);
    tick(2);
    chk(count, 8'h02);
    tick(3);
    chk(count, 8'h01);
    tick(8);
    chk(flag, 1);
  endtask
  task automatic t_restart;
    wr8(8'h2a, 8'h20);
    wr8(8'h2c, 8'h03);
    wr8(8'h2b, 8'h01);
    pulse(0);
    tick(10);
    chk(run, 1);
    wr8(8'h2c, 8'h05);
    tick(0);
    chk(count, 8'h01);
    pulse(0);
    chk(count, 8'h05);
  endtask
  task automatic t_halt;
    wr8(8'h2a, 8'h04);
    wr8(8'h2c, 8'h09);
    wr8(8'h2b, 8'h0d);
    pulse(0);
    pulse(2);
    chk({run, count}, 9'h009);
    pulse(0);
    pulse(3);
    chk(run, 0);
    wr8(8'h2c, 8'h00);
    wr8(8'h2b, 8'h03);
    pulse(0);
    pulse(1);
    chk(run, 0);
  endtask
  task automatic t_pin;
    for (int i = 0; i < 8; i++)
    begin
      wr8(8'h2d, {6'h00, i[1:0]});
      irqb <= i[2];
      tick(4);
      chk({pin, oe, seen}, {i[2] ^ i[1], i[0] | !(i[2] ^ i[1]), i[2] ^ i[1]});
    end
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      complete_run();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1;
    tick(1);
    for (int i = 0; i < 7; i++)
      rd8(8'h2a + i, i == 0 ? 8'h0b : (i == 1 || i == 3) ? 8'h02 : 8'h00);
    t_oneshot();
    t_prescale();
    t_restart();
    t_halt();
    t_pin();
    complete_run();
  end
endmodule
bind countdown_timer countdown_timer_monitor countdown_timer_monitor_inst (.*);
`default_nettype wire
